// ---- pkg/lfm_pkg.sv ----
// Constants, field layout and helpers for the limit and field move datapath.
// Assumes a 32-bit instruction word and a 512-word register memory.
package lfm_pkg;
  // Opcodes, instruction bits 31..26
  localparam logic [5:0] OP_CLAMP_LOW = 6'h12;
  localparam logic [5:0] OP_CLAMP_LOW_SIGNED = 6'h10;
  localparam logic [5:0] OP_COPY_WORD = 6'h28;
  localparam logic [5:0] OP_INSERT_DEST_FIELD = 6'h15;
  localparam logic [5:0] OP_INSERT_OPCODE_FIELD = 6'h16;
  localparam logic [5:0] OP_INSERT_SRC_FIELD = 6'h14;
  // Instruction word layout
  localparam int OP_HI = 31;
  localparam int OP_LO = 26;
  localparam int ZF_UPD_BIT = 25;
  localparam int CF_UPD_BIT = 24;
  localparam int WRITE_BIT = 23;
  localparam int IMM_BIT = 22;
  localparam int CND_HI = 21;
  localparam int CND_LO = 18;
  localparam int DST_HI = 17;
  localparam int DST_LO = 9;
  localparam int SRC_HI = 8;
  localparam int SRC_LO = 0;
  localparam int INS_HI = 31;
  localparam int INS_LO = 23;
  // Bus map: word indices of control registers; memory window at MEM_BIT
  localparam logic [8:0] REG_RUN = 9'h000;
  localparam logic [8:0] REG_STATUS = 9'h001;
  localparam logic [8:0] REG_FLAGS = 9'h002;
  localparam int MEM_BIT = 11;
  // Run register fields
  localparam int RUN_PC_HI = 8;
  localparam int RUN_CNT_LO = 16;
  localparam int RUN_CNT_HI = 25;
  // Status and flags register fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_Z_BIT = 1;
  localparam int ST_C_BIT = 2;
  localparam int ST_BAD_BIT = 3;
  localparam int ST_PC_LO = 16;
  localparam int FL_Z_BIT = 0;
  localparam int FL_C_BIT = 1;
  localparam int FL_BAD_CLR_BIT = 3;
  // Cycles per instruction: fetch, dest read, source read, execute
  localparam int EXEC_CYCLES = 4;
  localparam logic [8:0] PC_RST = 9'h000;

  function automatic logic [31:0] be_merge(input logic [31:0] old_w,
      input logic [31:0] new_w, input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old_w & ~m) | (new_w & m);
  endfunction
endpackage

// ---- pkg/lfm_alu_if.sv ----
// Operand and result bundle between the sequencer and the ALU.
// Purely combinational; no clock travels with it.
interface lfm_alu_if;
  logic [5:0] op;
  logic [31:0] dval;
  logic [31:0] sval;
  logic [31:0] result;
  logic zf;
  logic cf;
  logic c_def;
  logic known;
  modport core (output op, dval, sval,
                input result, zf, cf, c_def, known);
  modport alu (input op, dval, sval,
               output result, zf, cf, c_def, known);
endinterface

// ---- src/lfm_alu.sv ----
// Result and flag logic for the six supported instructions.
// Assumes operands already resolved; flag masking done by the caller.
module lfm_alu
  import lfm_pkg::*;
(
  // Operand and result bundle
  lfm_alu_if.alu bus
);
  always_comb begin
    bus.result = bus.dval;
    bus.zf = (bus.sval == 32'h0000_0000);
    bus.cf = 1'b0;
    bus.c_def = 1'b0;
    bus.known = 1'b1;
    case (bus.op)
      OP_CLAMP_LOW: begin
        bus.result = (bus.dval < bus.sval) ? bus.sval : bus.dval;
        bus.cf = (bus.dval < bus.sval);
        bus.c_def = 1'b1;
      end
      OP_CLAMP_LOW_SIGNED: begin
        bus.result = ($signed(bus.dval) < $signed(bus.sval)) ?
                     bus.sval : bus.dval;
        bus.cf = ($signed(bus.dval) < $signed(bus.sval));
        bus.c_def = 1'b1;
      end
      OP_COPY_WORD: begin
        bus.result = bus.sval;
        bus.cf = bus.sval[31];
        bus.c_def = 1'b1;
      end
      OP_INSERT_DEST_FIELD: begin
        bus.result = {bus.dval[31:DST_HI+1], bus.sval[8:0],
                      bus.dval[DST_LO-1:0]};
      end
      OP_INSERT_OPCODE_FIELD: begin
        bus.result = {bus.sval[8:0], bus.dval[INS_LO-1:0]};
      end
      OP_INSERT_SRC_FIELD: begin
        bus.result = {bus.dval[31:SRC_HI+1], bus.sval[8:0]};
      end
      default: begin
        bus.known = 1'b0;
      end
    endcase
  end
endmodule

// ---- src/lfm_regmem.sv ----
// Register memory: 512 words, one asynchronous read, one write port.
// Assumes the caller never needs two reads in one cycle.
module lfm_regmem
  import lfm_pkg::*;
(
  // Clock
  input wire logic clock,
  // Read port
  input wire logic [8:0] rd_addr,
  output logic [31:0] rd_data,
  // Write port
  input wire logic we,
  input wire logic [8:0] wr_addr,
  input wire logic [31:0] wr_data
);
  // Contents are undefined after power-up, as in a plain RAM
  logic [31:0] mem [512];

  always_ff @(posedge clock) begin
    if (we) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];
endmodule

// ---- src/lfm_datapath.sv ----
// Limit and field move datapath: sequencer, flags and Avalon-MM slave.
// Assumes a bus master that holds each request until waitrequest is low.
// Software loads instructions into the register memory, then starts a run.
//
// Notes on behaviour
// - Unsigned clamp keeps the larger of destination and source.
// - Unsigned clamp zero flag reflects a zero source, not the result.
// - Unsigned clamp carry is destination unsigned-below source.
// - Clamp result written back unless no_write_result is chosen.
// - Signed clamp keeps the larger in two's complement.
// - Signed clamp carry is destination signed-below source.
// - Signed clamp zero flag set only for a zero source.
// - Source is an addressed register or a nine-bit literal.
// - copy_word places the whole source into the destination.
// - copy_word carry takes source bit 31.
// - Moves set zero flag when the source is zero.
// - insert_dest_field replaces bits 17..9 only.
// - insert_opcode_field replaces bits 31..23 only.
// - insert_src_field replaces bits 8..0 only.
// - A write-back is invisible to the very next instruction fetch.
// - Opcodes 010110 and 010100; every instruction takes four cycles.
//
// Decided for this implementation: the register offsets and the Avalon-MM register port.
module lfm_datapath
  import lfm_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_RD_DEST,
    ST_RD_SRC,
    ST_EXEC,
    ST_FLUSH
  } lfm_state_t;

  typedef struct packed {
    lfm_state_t st;
    logic [8:0] pc;
    logic [9:0] left;
    logic [31:0] instr;
    logic [31:0] dval;
    logic [31:0] sval;
    logic zf;
    logic cf;
    logic bad;
    logic wb_pend;
    logic [8:0] wb_addr;
    logic [31:0] wb_data;
    logic waitreq;
    logic [31:0] rdata;
  } lfm_regs_t;

  localparam lfm_regs_t S_RST = '{
    st: ST_IDLE,
    pc: PC_RST,
    left: 10'h000,
    instr: 32'h0000_0000,
    dval: 32'h0000_0000,
    sval: 32'h0000_0000,
    zf: 1'b0,
    cf: 1'b0,
    bad: 1'b0,
    wb_pend: 1'b0,
    wb_addr: 9'h000,
    wb_data: 32'h0000_0000,
    waitreq: 1'b1,
    rdata: 32'h0000_0000
  };

  lfm_regs_t s_q;
  lfm_regs_t s_d;

  // Reset enters at once but leaves on a clock edge, so no register
  // sees the release land close to its own sampling edge.
  logic rst_meta_n_q;
  logic rst_sync_n_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n_q <= 1'b0;
      rst_sync_n_q <= 1'b0;
    end else begin
      rst_meta_n_q <= 1'b1;
      rst_sync_n_q <= rst_meta_n_q;
    end
  end

  // Memory port signals
  logic [8:0] mem_ra;
  logic [31:0] mem_rd;
  logic mem_we;
  logic [8:0] mem_wa;
  logic [31:0] mem_wd;

  // Bus decode
  logic bus_req;
  logic bus_is_mem;
  logic [8:0] bus_widx;
  logic bus_allowed;
  logic [31:0] bus_rval;

  // Instruction fields of the word being executed
  logic [8:0] f_dest;
  logic [8:0] f_src;
  logic [3:0] f_cond;
  logic cond_ok;

  lfm_alu_if alu_bus();

  lfm_alu u_alu (
    .bus(alu_bus)
  );

  lfm_regmem u_mem (
    .clock(clock),
    .rd_addr(mem_ra),
    .rd_data(mem_rd),
    .we(mem_we),
    .wr_addr(mem_wa),
    .wr_data(mem_wd)
  );

  assign f_dest = s_q.instr[DST_HI:DST_LO];
  assign f_src = s_q.instr[SRC_HI:SRC_LO];
  assign f_cond = s_q.instr[CND_HI:CND_LO];
  // Condition bit picked by the current carry and zero flags
  assign cond_ok = f_cond[{s_q.cf, s_q.zf}];

  assign alu_bus.op = s_q.instr[OP_HI:OP_LO];
  assign alu_bus.dval = s_q.dval;
  assign alu_bus.sval = s_q.sval;

  assign bus_req = avs_read | avs_write;
  assign bus_is_mem = avs_address[MEM_BIT];
  assign bus_widx = avs_address[10:2];
  // Status stays readable during a run; everything else waits for idle
  // so the bus never competes with the sequencer for the memory port.
  assign bus_allowed = (s_q.st == ST_IDLE) ||
                       (avs_read && !bus_is_mem && bus_widx == REG_STATUS);

  always_comb begin
    bus_rval = 32'h0000_0000;
    if (bus_is_mem) begin
      bus_rval = mem_rd;
    end else begin
      case (bus_widx)
        REG_RUN: begin
          bus_rval[RUN_PC_HI:0] = s_q.pc;
          bus_rval[RUN_CNT_HI:RUN_CNT_LO] = s_q.left;
        end
        REG_STATUS: begin
          bus_rval[ST_BUSY_BIT] = (s_q.st != ST_IDLE);
          bus_rval[ST_Z_BIT] = s_q.zf;
          bus_rval[ST_C_BIT] = s_q.cf;
          bus_rval[ST_BAD_BIT] = s_q.bad;
          bus_rval[ST_PC_LO+8:ST_PC_LO] = s_q.pc;
        end
        REG_FLAGS: begin
          bus_rval[FL_Z_BIT] = s_q.zf;
          bus_rval[FL_C_BIT] = s_q.cf;
        end
        default: begin
          bus_rval = 32'h0000_0000;
        end
      endcase
    end
  end

  always_comb begin
    s_d = s_q;
    mem_ra = bus_widx;
    mem_we = 1'b0;
    mem_wa = bus_widx;
    mem_wd = 32'h0000_0000;

    // Bus handshake: one ack cycle, write lands at the completing edge
    if (!s_q.waitreq) begin
      s_d.waitreq = 1'b1;
      if (avs_write) begin
        if (bus_is_mem) begin
          mem_we = 1'b1;
          mem_wd = be_merge(mem_rd, avs_writedata, avs_byteenable);
        end else begin
          case (bus_widx)
            REG_RUN: begin
              if (avs_byteenable == 4'hf &&
                  avs_writedata[RUN_CNT_HI:RUN_CNT_LO] != 10'h000) begin
                s_d.pc = avs_writedata[RUN_PC_HI:0];
                s_d.left = avs_writedata[RUN_CNT_HI:RUN_CNT_LO];
                s_d.st = ST_FETCH;
              end
            end
            REG_FLAGS: begin
              if (avs_byteenable[0]) begin
                s_d.zf = avs_writedata[FL_Z_BIT];
                s_d.cf = avs_writedata[FL_C_BIT];
                if (avs_writedata[FL_BAD_CLR_BIT]) begin
                  s_d.bad = 1'b0;
                end
              end
            end
            default: begin
              s_d.bad = s_q.bad;
            end
          endcase
        end
      end
    end else if (bus_req && bus_allowed) begin
      s_d.waitreq = 1'b0;
      if (avs_read) begin
        s_d.rdata = bus_rval;
      end
    end

    case (s_q.st)
      ST_IDLE: begin
        s_d.wb_pend = s_q.wb_pend;
      end
      ST_FETCH: begin
        mem_ra = s_q.pc;
        s_d.instr = mem_rd;
        s_d.st = ST_RD_DEST;
      end
      ST_RD_DEST: begin
        mem_ra = f_dest;
        // The previous result lands only after this word was fetched
        if (s_q.wb_pend) begin
          mem_we = 1'b1;
          mem_wa = s_q.wb_addr;
          mem_wd = s_q.wb_data;
          s_d.wb_pend = 1'b0;
        end
        if (s_q.wb_pend && s_q.wb_addr == f_dest) begin
          s_d.dval = s_q.wb_data;
        end else begin
          s_d.dval = mem_rd;
        end
        s_d.st = ST_RD_SRC;
      end
      ST_RD_SRC: begin
        mem_ra = f_src;
        if (s_q.instr[IMM_BIT]) begin
          s_d.sval = {23'h000000, f_src};
        end else begin
          s_d.sval = mem_rd;
        end
        s_d.st = ST_EXEC;
      end
      ST_EXEC: begin
        if (cond_ok) begin
          if (!alu_bus.known) begin
            s_d.bad = 1'b1;
          end else begin
            if (s_q.instr[ZF_UPD_BIT]) begin
              s_d.zf = alu_bus.zf;
            end
            if (s_q.instr[CF_UPD_BIT] && alu_bus.c_def) begin
              s_d.cf = alu_bus.cf;
            end
            if (s_q.instr[WRITE_BIT]) begin
              s_d.wb_pend = 1'b1;
              s_d.wb_addr = f_dest;
              s_d.wb_data = alu_bus.result;
            end
          end
        end
        s_d.pc = s_q.pc + 9'h001;
        s_d.left = s_q.left - 10'h001;
        s_d.st = (s_q.left == 10'h001) ? ST_FLUSH : ST_FETCH;
      end
      ST_FLUSH: begin
        // Last result of a run must not be lost at the return to idle
        if (s_q.wb_pend) begin
          mem_we = 1'b1;
          mem_wa = s_q.wb_addr;
          mem_wd = s_q.wb_data;
          s_d.wb_pend = 1'b0;
        end
        s_d.st = ST_IDLE;
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      s_q <= S_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = s_q.waitreq;
endmodule

// ---- sim/lfm_datapath_asserts.sv ----
// Bus timing checks on the datapath's Avalon-MM slave port.
// Assumes a host that holds each request until waitrequest is low.
module lfm_datapath_asserts (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] left_q;
  logic run_go;
  logic st_rd;
  assign st_rd = avs_read && avs_address == 12'h004;
  assign run_go = !avs_waitrequest && avs_write && avs_address == 12'h000
      && avs_byteenable == 4'hf && avs_writedata[25:16] != 10'h000;
  // Run cycles still owed: four per instruction plus one flush
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) left_q <= 12'h000;
    else if (run_go) left_q <= {avs_writedata[25:16], 2'b01};
    else if (left_q != 12'h000) left_q <= left_q - 12'h001;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_wait_pulse;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("wait low");
  property p_wait_cause;
    !avs_waitrequest |-> $past(avs_read || avs_write);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("no req");
  property p_rdata_hold;
    !$stable(avs_readdata) |-> !avs_waitrequest && avs_read;
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("rdata");
  property p_first_edge;
    $rose(rst_n) |-> avs_waitrequest;
  endproperty
  a_first_edge: assert property (p_first_edge) else $error("reset");
  // A run owns the memory: only status reads get through
  property p_run_stall;
    left_q > 12'h001 && (avs_read || avs_write) && !st_rd |-> avs_waitrequest;
  endproperty
  a_run_stall: assert property (p_run_stall) else $error("stall");
  property p_status_live;
    st_rd && avs_waitrequest |-> ##[1:2] !avs_waitrequest;
  endproperty
  a_status_live: assert property (p_status_live) else $error("st");
  property p_idle_answer;
    (avs_read || avs_write) && avs_waitrequest && left_q == 12'h000
        |-> ##[1:3] !avs_waitrequest;
  endproperty
  a_idle_answer: assert property (p_idle_answer) else $error("idle");
  property p_busy_bit;
    st_rd && !avs_waitrequest && left_q > 12'h002 |-> avs_readdata[0];
  endproperty
  a_busy_bit: assert property (p_busy_bit) else $error("busy");
endmodule
bind lfm_datapath lfm_datapath_asserts u_lfm_datapath_asserts (
  .clock(clock), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

// ---- sim/lfm_host_bfm.sv ----
// Host model: Avalon-MM master that loads programs and starts runs.
// Assumes one caller at a time, each call entered after a clock edge.
module lfm_host_bfm (
  // Clock
  input wire logic clock,
  // Avalon-MM master side
  output logic [11:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    avs_address = 12'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
  end
  task automatic xfer(input logic wr, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    @(posedge clock);
    while (avs_waitrequest) @(posedge clock);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Idle lines show junk so nothing can lean on stale values
    avs_address <= ~a;
    avs_writedata <= ~d;
  endtask
endmodule

// ---- sim/lfm_datapath_test.sv ----
// Bench: random four-instruction programs, self-modifying ones too,
// run from register memory and compared with a behavioural model.
module lfm_datapath_test
  import lfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  int n_fail = 0;
  int checks_done = 0;
  int seed = 32'h3349;
  int cycles = 0;
  logic [31:0] m [512];
  logic mz = 1'b0;
  logic mc = 1'b0;
  logic mb = 1'b0;
  logic [5:0] ops [6] = '{OP_CLAMP_LOW, OP_CLAMP_LOW_SIGNED, OP_COPY_WORD,
      OP_INSERT_DEST_FIELD, OP_INSERT_OPCODE_FIELD, OP_INSERT_SRC_FIELD};
  logic [31:0] corner [4] = '{32'h0, 32'h1, 32'hffffffff, 32'h7fffffff};
  always #2.5 clock = ~clock;
  lfm_host_bfm u_lfm_host_bfm (.clock(clock), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  lfm_datapath u_lfm_datapath (.clock(clock), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rw(logic wr, logic [11:0] a, logic [31:0] d, output
      logic [31:0] q);
    u_lfm_host_bfm.xfer(wr, a, d, q);
  endtask
  function automatic logic [8:0] slot(int i);
    return 9'(i < 5 ? 32 + i : 43 + i);
  endfunction
  // Results land one fetch late, so the next word runs unmodified
  task automatic model(int pc, int n);
    logic [31:0] w, dv, sv, r;
    logic ok, pend, cu, cs;
    int pa;
    pend = 1'b0;
    pa = 0;
    r = 32'h0;
    for (int k = 0; k < n; k++) begin
      w = m[pc];
      if (pend) m[pa] = r;
      pa = w[DST_HI:DST_LO];
      dv = m[pa];
      sv = w[IMM_BIT] ? {23'h0, w[SRC_HI:SRC_LO]} : m[w[SRC_HI:SRC_LO]];
      ok = w[CND_LO + {mc, mz}];
      cu = dv < sv;
      cs = $signed(dv) < $signed(sv);
      case (w[OP_HI:OP_LO])
        OP_CLAMP_LOW: r = cu ? sv : dv;
        OP_CLAMP_LOW_SIGNED: r = cs ? sv : dv;
        OP_COPY_WORD: r = sv;
        OP_INSERT_DEST_FIELD: r = {dv[31:18], sv[8:0], dv[8:0]};
        OP_INSERT_OPCODE_FIELD: r = {sv[8:0], dv[22:0]};
        OP_INSERT_SRC_FIELD: r = {dv[31:9], sv[8:0]};
        default: begin
          mb = mb | ok;
          ok = 1'b0;
        end
      endcase
      if (ok && w[ZF_UPD_BIT]) mz = sv == 32'h0;
      if (ok && w[CF_UPD_BIT]) mc = w[OP_HI:OP_LO] == OP_CLAMP_LOW ? cu :
          w[OP_HI:OP_LO] == OP_CLAMP_LOW_SIGNED ? cs :
          w[OP_HI:OP_LO] == OP_COPY_WORD ? sv[31] : mc;
      pend = ok && w[WRITE_BIT];
      pc = (pc + 1) % 512;
    end
    if (pend) m[pa] = r;
  endtask
  initial begin
    logic [31:0] q, r;
    int t0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    rw(1'b0, 12'h008, 32'h0, q);
    chk("flags", 32'h0, q);
    rw(1'b1, 12'h00c, 32'hffffffff, q);
    rw(1'b0, 12'h00c, 32'h0, q);
    chk("unmapped", 32'h0, q);
    // Fill every word so a redirected operand never reads an unknown
    for (int a = 0; a < 512; a++) begin
      m[a] = $random(seed);
      rw(1'b1, {1'b1, 9'(a), 2'b00}, m[a], q);
    end
    for (int t = 0; t < 40; t++) begin
      for (int i = 0; i < 9; i++) begin
        r = $random(seed);
        q = r[31] ? r : corner[r[1:0]];
        if (i < 4) q = {ops[(4 * t + i) % 6], r[25:22],
            t % 5 == 4 ? r[21:18] : 4'hf,
            r[2] ? 9'h030 + r[1:0] : 9'h021 + r[1:0],
            r[22] ? (r[5] ? r[14:6] : {9{r[4]}}) : 9'h030 + r[16:15]};
        m[slot(i)] = q;
        rw(1'b1, {1'b1, slot(i), 2'b00}, q, r);
      end
      r = $random(seed);
      mz = r[0];
      mc = r[1];
      if (r[2]) mb = 1'b0;
      rw(1'b1, 12'h008, {28'h0, r[2], 1'b0, mc, mz}, q);
      rw(1'b1, 12'h000, 32'h00040020, q);
      t0 = cycles;
      rw(1'b0, 12'h004, 32'h0, q);
      chk("busy", 32'h1, {31'h0, q[0]});
      model(32, 4);
      for (int i = 0; i < 9; i++) begin
        rw(1'b0, {1'b1, slot(i), 2'b00}, 32'h0, q);
        if (i == 0) chk("run time", 32'h1, {31'h0, cycles - t0 >= 17 &&
            cycles - t0 <= 23});
        chk("word", m[slot(i)], q);
      end
      rw(1'b0, 12'h008, 32'h0, q);
      chk("flags", {30'h0, mc, mz}, q);
      rw(1'b0, 12'h004, 32'h0, q);
      chk("status word", {7'h0, 9'h024, 12'h0, mb, mc, mz, 1'b0}, q);
      rw(1'b0, 12'h000, 32'h0, q);
      chk("run reg", 32'h0000_0024, q);
    end
    rw(1'b1, 12'h000, 32'h00000020, q);
    rw(1'b0, 12'h004, 32'h0, q);
    chk("zero count", 32'h0, {31'h0, q[0]});
    rw(1'b1, 12'h000, 32'h00040020, q);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rw(1'b0, 12'h004, 32'h0, q);
    chk("status", 32'h0, q);
    print_verdict();
  end
endmodule
